/* File: logic/host_port.sv */
// Design: eight-bit parallel host port with hook-switch interrupt
`timescale 1ns/1ps

// What this block does
// - Three-bit reg_select picks the register read or written on each access.
// - Strobes are ignored unless chip select is low.
// - Data bus is eight bits, bit 0 least significant, high means one.
// - Data lines are inputs during write, driven during read with select.
// - Data lines released when select is high or no strobe is active.
// - Interrupt request is driven low for service, high otherwise.
// - Interrupt output is pulled low only on the 125 microsecond frame tick.
// - Interrupt stays low until the cause register is read or reset.
// - Every hook-switch edge, rising or falling, raises an interrupt.
// - Reset high aborts activity at the next mclk rising edge and loads the reset state.
// - On reset release the device starts in the idle power mode.
// - The master clock output keeps toggling while reset is held.
// - Read drives selected register after the read strobe falls.
// - Write captures the data bus at the write strobe rising edge.
module host_port (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire host_port_pkg::host_in_t host_in,
    input  wire logic                    hook_switch_in,
    output      host_port_pkg::host_out_t host_out,
    output      logic                    int_n,
    output      logic                    mclk_out,
    output      logic [1:0]              power_mode
);
    import host_port_pkg::*;

    // ------------------------------------------------------------------
    // Strobe synchronisers
    // ------------------------------------------------------------------
    // Strobes are gated with chip select before synchronising so a
    // strobe seen without select never becomes an access.
    logic       rd_meta_r;
    logic       rd_sync_r;
    logic       wr_meta_r;
    logic       wr_sync_r;
    logic       hook_meta_r;
    logic       hook_sync_r;
    logic       hook_prev_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_meta_r <= 1'b0;
            rd_sync_r <= 1'b0;
            wr_meta_r <= 1'b0;
            wr_sync_r <= 1'b0;
        end else begin
            rd_meta_r <= ~host_in.cs_n & ~host_in.rd_n;
            rd_sync_r <= rd_meta_r;
            wr_meta_r <= ~host_in.cs_n & ~host_in.wr_n;
            wr_sync_r <= wr_meta_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hook_meta_r <= 1'b1;
            hook_sync_r <= 1'b1;
        end else begin
            hook_meta_r <= hook_switch_in;
            hook_sync_r <= hook_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Access sequencing
    // ------------------------------------------------------------------
    strobe_state_t state_r;
    strobe_state_t state_nxt;
    logic          rd_start;
    logic          wr_done;

    always_comb begin
        state_nxt = state_r;
        rd_start  = 1'b0;
        wr_done   = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (rd_sync_r) begin
                    state_nxt = ST_READ;
                    rd_start  = 1'b1;
                end else if (wr_sync_r) begin
                    state_nxt = ST_WRITE;
                end
            end
            ST_READ: begin
                if (!rd_sync_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (!wr_sync_r) begin
                    state_nxt = ST_IDLE;
                    wr_done   = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Write data and select are held from the last strobe-active cycle,
    // since the host may change them right as the write strobe rises.
    logic [7:0] wr_data_r;
    logic [2:0] wr_sel_r;
    logic [2:0] rd_sel_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_data_r <= 8'h00;
            wr_sel_r  <= 3'h0;
            rd_sel_r  <= 3'h0;
        end else begin
            if (state_r == ST_WRITE && wr_meta_r) begin
                wr_data_r <= host_in.data_in;
                wr_sel_r  <= host_in.reg_select;
            end
            if (rd_start) begin
                rd_sel_r <= host_in.reg_select;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] regs_r [NUM_REGS];
    logic       cause_hook_r;
    logic       cause_read;

    assign cause_read = rd_start && host_in.reg_select == SEL_INT_CAUSE;

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= SCRATCH_RESET;
            end
        end else if (wr_done && wr_sel_r != SEL_INT_CAUSE) begin
            regs_r[wr_sel_r] <= wr_data_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            power_mode <= MODE_IDLE;
        end else if (wr_done && wr_sel_r == SEL_POWER_MODE) begin
            power_mode <= wr_data_r[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Hook-switch interrupt
    // ------------------------------------------------------------------
    logic hook_edge;

    always_ff @(posedge mclk) begin
        if (rst) begin
            hook_prev_r <= 1'b1;
        end else begin
            hook_prev_r <= hook_sync_r;
        end
    end

    assign hook_edge = hook_sync_r ^ hook_prev_r;

    // A new edge in the cycle of the cause read wins over the clear.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cause_hook_r <= 1'b0;
        end else if (hook_edge) begin
            cause_hook_r <= 1'b1;
        end else if (cause_read) begin
            cause_hook_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin refresh
    // ------------------------------------------------------------------
    // Pending state is sampled only on the frame tick; the pin is
    // released early only by a cause read, never by a tick alone.
    logic [TICK_W-1:0] tick_cnt_r;
    logic              tick;

    assign tick = tick_cnt_r == TICK_LAST;

    always_ff @(posedge mclk) begin
        if (rst || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + TICK_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            int_n <= 1'b1;
        end else if (cause_read) begin
            int_n <= 1'b1;
        end else if (tick && cause_hook_r) begin
            int_n <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data and bus drive
    // ------------------------------------------------------------------
    logic [7:0] rd_data_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data_r <= 8'h00;
        end else if (rd_start) begin
            if (host_in.reg_select == SEL_INT_CAUSE) begin
                rd_data_r <= 8'h00;
                rd_data_r[CAUSE_HOOK_BIT] <= cause_hook_r | hook_edge;
                rd_data_r[HOOK_LEVEL_BIT] <= hook_sync_r;
            end else begin
                rd_data_r <= regs_r[host_in.reg_select];
            end
        end
    end

    // Enable follows the raw pins so the bus releases without delay.
    always_comb begin
        host_out.data_out = rd_data_r;
        host_out.data_oe  = ~host_in.cs_n & ~host_in.rd_n
                            & host_in.wr_n;
    end

    // ------------------------------------------------------------------
    // Master clock out
    // ------------------------------------------------------------------
    // Free running, outside reset so it keeps toggling while reset holds.
    logic mclk_div_r = 1'b0;

    always_ff @(posedge mclk) begin
        mclk_div_r <= ~mclk_div_r;
    end

    assign mclk_out = mclk_div_r;

    logic unused_sel;
    assign unused_sel = ^rd_sel_r;

endmodule // host_port

/* File: pkg/host_port_pkg.sv */
// Package: constants and carrier types for the parallel host port
package host_port_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned MCLK_MHZ          = 200;
    localparam int unsigned IRQ_PERIOD_US     = 125;
    localparam int unsigned IRQ_PERIOD_CYCLES = IRQ_PERIOD_US * MCLK_MHZ;
    localparam int unsigned TICK_W            = 15;
    localparam logic [TICK_W-1:0] TICK_LAST   =
        TICK_W'(IRQ_PERIOD_CYCLES - 1);

    // ------------------------------------------------------------------
    // Register map (3-bit select, eight byte registers)
    // ------------------------------------------------------------------
    localparam int unsigned NUM_REGS          = 8;
    localparam logic [2:0] SEL_INT_CAUSE      = 3'h0;
    localparam logic [2:0] SEL_POWER_MODE     = 3'h1;
    localparam logic [7:0] SCRATCH_RESET      = 8'h00;
    localparam int unsigned CAUSE_HOOK_BIT    = 0;
    localparam int unsigned HOOK_LEVEL_BIT    = 1;

    // Power mode codes held in the power mode register
    localparam logic [1:0] MODE_IDLE          = 2'h0;
    localparam logic [1:0] MODE_ACTIVE_DATA   = 2'h1;
    localparam logic [1:0] MODE_ACTIVE_VOICE  = 2'h3;
    localparam logic [1:0] MODE_POWER_DOWN    = 2'h2;

    // Strobe tracking states, Gray coded along idle->read/write->idle
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } strobe_state_t;

    // Host side pins of the port
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] reg_select;
        logic [7:0] data_in;
    } host_in_t;

    typedef struct packed {
        logic [7:0] data_out;
        logic       data_oe;
    } host_out_t;

endpackage : host_port_pkg

/* File: testbench/host_cpu_model.sv */
// Partner: behavioural host processor driving the parallel bus
`timescale 1ns/1ps
module host_cpu_model
    import host_port_pkg::*;
(
    input  wire logic                     mclk,
    output      host_port_pkg::host_in_t  host_in,
    input  wire host_port_pkg::host_out_t host_out
);
    logic       cs_n = 1'b1;
    logic       rd_n = 1'b1;
    logic       wr_n = 1'b1;
    logic [2:0] sel  = 3'h0;
    logic [7:0] drv  = 8'h00;
    // Wire: device drive wins; when released the host flips its last
    // byte so a stale value never reads as valid
    assign host_in = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, reg_select: sel,
        data_in: host_out.data_oe ? host_out.data_out : drv};
    task automatic acc(input logic w, input logic c_n, input logic [2:0] s,
                       input logic [7:0] d, output logic [7:0] q);
        @(negedge mclk);
        cs_n = c_n;
        sel = s;
        drv = w ? d : ~drv;
        rd_n = w;
        wr_n = !w;
        repeat (5) @(negedge mclk);
        q = host_in.data_in;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        @(negedge mclk);
        drv = ~drv;
        repeat (2) @(negedge mclk);
    endtask
endmodule // host_cpu_model

/* File: testbench/host_port_assertions.sv */
// Checker: port timing and gating properties of the host port
`timescale 1ns/1ps
module host_port_checker
    import host_port_pkg::*;
(
    input wire logic                     mclk,
    input wire logic                     rst,
    input wire host_port_pkg::host_in_t  host_in,
    input wire logic                     hook_switch_in,
    input wire host_port_pkg::host_out_t host_out,
    input wire logic                     int_n,
    input wire logic                     mclk_out,
    input wire logic [1:0]               power_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Mirrors the frame counter; both are cleared by reset
    logic [TICK_W-1:0] cnt_r;
    always_ff @(posedge mclk) begin
        cnt_r <= (rst || cnt_r == TICK_LAST) ? '0 : cnt_r + TICK_W'(1);
    end
    sequence seq_cause_read;
        $fell(host_in.rd_n) && !host_in.cs_n &&
        host_in.reg_select == SEL_INT_CAUSE
        ##1 (!host_in.rd_n && !host_in.cs_n) [*3];
    endsequence
    sequence seq_no_select;
        host_in.cs_n [*5];
    endsequence
    a_oe_drive: assert property (!host_in.cs_n && !host_in.rd_n &&
        host_in.wr_n |-> host_out.data_oe) else $error("bus not driven");
    a_oe_release: assert property (host_in.cs_n || !host_in.wr_n ||
        host_in.rd_n |-> !host_out.data_oe) else $error("bus not released");
    a_clk_alive: assert property (disable iff (1'b0) rst ##1 rst
        |-> mclk_out != $past(mclk_out)) else $error("clock out stalled");
    a_reset_state: assert property (disable iff (1'b0) rst |=>
        int_n && power_mode == MODE_IDLE && host_out.data_out == 8'h00)
        else $error("reset state wrong");
    a_int_tick: assert property ($fell(int_n) |->
        (cnt_r < TICK_W'(3) || cnt_r == TICK_LAST))
        else $error("interrupt off frame");
    a_int_hold: assert property (!int_n && host_in.cs_n |=> !int_n)
        else $error("interrupt dropped early");
    a_cause_clear: assert property (seq_cause_read |-> ##[0:1] int_n)
        else $error("interrupt not cleared");
    a_data_stands: assert property (host_in.rd_n [*4] |=>
        $stable(host_out.data_out)) else $error("read data moved");
    a_cs_gate: assert property (seq_no_select |-> $stable(power_mode))
        else $error("write taken without select");
endmodule // host_port_checker

bind host_port host_port_checker chk_i (
    .mclk(mclk), .rst(rst), .host_in(host_in),
    .hook_switch_in(hook_switch_in), .host_out(host_out),
    .int_n(int_n), .mclk_out(mclk_out), .power_mode(power_mode));

/* File: testbench/tb_host_port.sv */
// Testbench: self-checking run of the host port against a bench model
`timescale 1ns/1ps
module tb_host_port;
    import host_port_pkg::*;
    logic       mclk = 1'b0;
    logic       rst  = 1'b1;
    logic       hook = 1'b1;
    host_in_t   hin;
    host_out_t  hout;
    logic       int_n;
    logic       mclk_out;
    logic [1:0] pm;
    logic [7:0] q;
    int         miscompares = 0;
    int         total_checks = 0;
    int         seed = 55935;
    int         cause = 0;
    int         mdl[8];

    always #2.5 mclk = ~mclk;

    host_port DUT (.mclk(mclk), .rst(rst), .host_in(hin),
        .hook_switch_in(hook), .host_out(hout), .int_n(int_n),
        .mclk_out(mclk_out), .power_mode(pm));
    host_cpu_model cpu (.mclk(mclk), .host_in(hin), .host_out(hout));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input int s);
        logic [7:0] e;
        e = (s == 0) ? 8'({hook, cause[0]}) : 8'(mdl[s]);
        if (s == 0) cause = 0;
        cpu.acc(1'b0, 1'b0, 3'(s), 8'h00, q);
        chk(q, e);
    endtask

    task automatic wr(input int s, input int d);
        cpu.acc(1'b1, 1'b0, 3'(s), 8'(d), q);
        if (s != 0) mdl[s] = d & 'hff;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge mclk);
        miscompares++;
        stop_test();
    end

    initial begin
        mdl = '{default: 0};
        repeat (16) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        chk({6'h0, pm}, {6'h0, MODE_IDLE});
        chk({7'h0, int_n}, 8'h01);
        for (int s = 0; s < 8; s++) rd(s);
        for (int s = 2; s < 8; s++) wr(s, $random(seed));
        for (int s = 2; s < 8; s++) rd(s);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            wr(1, m);
            chk({6'h0, pm}, 8'(m));
            rd(1);
        end
        cpu.acc(1'b1, 1'b1, 3'h2, 8'(~mdl[2]), q);
        rd(2);
        $display("test modes and select done");
        // Each pass flips the hook level, so both edge directions are seen
        for (int k = 0; k < 2; k++) begin
            @(negedge mclk) hook = ~hook;
            cause = 1;
            repeat (25010) @(negedge mclk);
            chk({7'h0, int_n}, 8'h00);
            rd(0);
            chk({7'h0, int_n}, 8'h01);
            rd(0);
        end
        $display("test interrupt done");
        wr(1, 3);
        wr(2, 'h5a);
        @(negedge mclk) rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        mdl = '{default: 0};
        chk({6'h0, pm}, 8'h00);
        rd(2);
        $display("test reset done");
        stop_test();
    end
endmodule // tb_host_port
